// file: pkg/gcfg_defines.svh
/*
 * Offsets, field positions and reset values of the global configuration
 * register bank. Assumes inclusion by bare name from the design file.
 */
`ifndef GCFG_DEFINES_SVH
`define GCFG_DEFINES_SVH

// Register indices; byte address is four times the index
`define GCFG_IDX_BANK_SEL 8'h00
`define GCFG_IDX_MCFG_ONE 8'h09
`define GCFG_IDX_MCFG_TWO 8'h0A
`define GCFG_IDX_IN_EN 8'h0C
`define GCFG_IDX_OUT_EN 8'h0D
`define GCFG_IDX_PCFG_LO 8'h0E
`define GCFG_IDX_PCFG_HI 8'h0F
`define GCFG_IDX_PSEL0 8'h12
`define GCFG_IDX_PSEL3 8'h15
`define GCFG_IDX_STAT_BASE 8'h40
`define GCFG_IDX_PIN_LEVEL 8'h41
`define GCFG_IDX_STAT_LAST 8'h5F

// Field positions
`define GCFG_SOFT_RST_BIT 7
`define GCFG_XMODE_LSB 0
`define GCFG_EXTSRC_LSB 5
`define GCFG_SEL_REG_LSB 3

// Reset values and masks
`define GCFG_ZERO8 8'h00
`define GCFG_MCFG_ONE_MASK 8'h83
`define GCFG_MCFG_TWO_MASK 8'h60
`define GCFG_EN3_MASK 8'h07

// AXI responses
`define GCFG_RESP_OKAY 2'h0
`define GCFG_RESP_SLVERR 2'h2

`endif

// file: pkg/gcfg_pkg.sv
/*
 * Types of the global configuration register bank.
 * Assumes the defines header is compiled alongside.
 */
package gcfg_pkg;
    typedef enum logic [3:0] {
        GCFG_PIN_IN       = 4'h0,
        GCFG_PIN_IN_INV   = 4'h1,
        GCFG_PIN_OUT_LO   = 4'h2,
        GCFG_PIN_OUT_HI   = 4'h3,
        GCFG_PIN_STAT     = 4'h4,
        GCFG_PIN_STAT_INV = 4'h5,
        GCFG_PIN_STAT_OD0 = 4'h6,
        GCFG_PIN_STAT_OD1 = 4'h7
    } gcfg_pin_mode_e;
    typedef logic [7:0] gcfg_byte_t;
endpackage

// file: src/gcfg_regs.sv
/*
 * Global configuration register bank with four configurable pins, reached
 * over AXI4-Lite. Assumes one clock, a synchronous active-high reset, an
 * external block supplying status registers 0x40..0x5F (with an implemented
 * bit mask), and pin pads resolved outside from out/oe.
 * Pin drive and bus answers come from flops; the status selection ahead of
 * the pin flops is combinational, so a status change shows one clock later.
 * Writes use only byte lane 0; the upper lanes read as zero.
 * Holding clk_en low freezes everything except the reset paths.
 */
// Local design decision: the AXI4-Lite interface to the registers.
// How it works
// [R1] Bit 0 of register 0x00 picks device registers (0) or memory (1).
// [R2] The bank selector is write-only and always reads back as zero.
// [R3] Soft reset bit in 0x09 holds the core in reset and returns the other fields to default.
// [R4] Pin-strapped defaults reload the values caught at hardware reset.
// [R5] The two-bit crystal mode selects off, crystal, or external oscillator.
// [R6] Bits 6:5 of 0x0A pick the external switch pin when that is enabled.
// [R7] Bits 2:0 of 0x0C enable input clocks three, two and one.
// [R8] Bits 2:0 of 0x0D enable outputs three, two and one and their logic.
// [R9] Codes 0000..0011 give input, inverted input, drive low, drive high.
// [R10] Codes 0100..0111 give follow, inverted, low-on-0, low-on-1 status.
// [R11] Pin level status reports the live level of every pin.
// [R12] 0x0E holds pins 1 and 0, 0x0F holds pins 3 and 2, high nibble first.
// [R13] Status pins follow register 0x40 plus the selector in bits 7:3.
// [R14] A selection of an unimplemented status bit reads as status 0, so the follow code drives the pin low.
// [R15] Bits 2:0 of the select register choose the bit in that register.
// [R16] A status pin never follows the pin level status register.
`timescale 1ns/1ns
`include "gcfg_defines.svh"

module gcfg_regs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // AXI4-Lite slave
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Strap pin for the crystal mode, caught at hardware reset
    input wire logic [1:0] crystal_mode_strap,
    // External status registers 0x40..0x5F, bytes packed by index
    input wire logic [255:0] status_bits,
    input wire logic [255:0] status_impl,
    // General-purpose pins
    input wire logic [3:0] gpio_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    // Controls toward the rest of the device
    output logic eeprom_bank_select,
    output logic core_reset,
    output logic [1:0] crystal_pin_mode,
    output logic ext_switch_pin,
    input wire logic ext_switch_enable,
    output logic [2:0] input_clock_enables,
    output logic [2:0] output_clock_enables
);

    // Registers
    logic bank_sel_ff;
    logic soft_rst_ff;
    logic [1:0] strap_ff;
    logic [1:0] xmode_ff;
    logic [1:0] extsrc_ff;
    logic [2:0] in_en_ff;
    logic [2:0] out_en_ff;
    logic [15:0] pcfg_ff;
    logic [31:0] psel_ff;

    // Pin synchroniser and pin drive
    logic [3:0] pin_meta_ff;
    logic [3:0] pin_sync_ff;
    logic [3:0] gpio_out_ff;
    logic [3:0] gpio_oe_ff;

    // Write channel: parked halves and the response
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] aw_idx_ff;
    logic [7:0] wdat_ff;
    logic wstb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;

    // Read channel response
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Write channel handshakes; each address/data is held once taken
    wire aw_take = s_axi_awvalid && !aw_got_ff && !bvalid_ff;
    wire w_take = s_axi_wvalid && !w_got_ff && !bvalid_ff;
    wire aw_have = aw_got_ff || aw_take;
    wire w_have = w_got_ff || w_take;
    wire wr_fire = aw_have && w_have && clk_en;
    wire [7:0] wr_idx = aw_got_ff ? aw_idx_ff : s_axi_awaddr[9:2];
    wire [7:0] wr_dat = w_got_ff ? wdat_ff : s_axi_wdata[7:0];
    wire wr_stb = w_got_ff ? wstb_ff : s_axi_wstrb[0];
    // A write with strobe 0 low still answers but changes nothing
    wire wr_en = wr_fire && wr_stb;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff && clk_en;
    assign s_axi_wready = !w_got_ff && !bvalid_ff && clk_en;
    assign s_axi_arready = !rvalid_ff && clk_en;

    // Write decode
    wire sel_bank = wr_idx == `GCFG_IDX_BANK_SEL;
    wire sel_m1 = wr_idx == `GCFG_IDX_MCFG_ONE;
    wire sel_m2 = wr_idx == `GCFG_IDX_MCFG_TWO;
    wire sel_ien = wr_idx == `GCFG_IDX_IN_EN;
    wire sel_oen = wr_idx == `GCFG_IDX_OUT_EN;
    wire sel_plo = wr_idx == `GCFG_IDX_PCFG_LO;
    wire sel_phi = wr_idx == `GCFG_IDX_PCFG_HI;
    // One status select register per pin, in pin order
    wire sel_ps = wr_idx >= `GCFG_IDX_PSEL0 && wr_idx <= `GCFG_IDX_PSEL3;
    wire [1:0] ps_slot = 2'(wr_idx - `GCFG_IDX_PSEL0);
    wire wr_known = sel_bank || sel_m1 || sel_m2 || sel_ien || sel_oen ||
        sel_plo || sel_phi || sel_ps;

    // While soft reset is high every field but that bit is held at default
    // The bus keeps running so software can clear the bit again
    wire hold_rst = reset || soft_rst_ff; // R3

    // Hardware reset catches the strap on its release edge; not gated by
    // clk_en, so the copy always matches what reset loads into the field
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strap_ff <= crystal_mode_strap; // R4
        end
    end

    // Soft reset bit itself only cleared by hardware reset or software
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            soft_rst_ff <= 1'b0;
        end else if (clk_en && wr_en && sel_m1) begin
            soft_rst_ff <= wr_dat[`GCFG_SOFT_RST_BIT]; // R3
        end
    end

    // Configuration fields
    always_ff @(posedge ref_clk) begin
        if (hold_rst) begin
            bank_sel_ff <= 1'b0;
            xmode_ff <= reset ? crystal_mode_strap : strap_ff; // R4
            extsrc_ff <= 2'h0;
            in_en_ff <= 3'h0;
            out_en_ff <= 3'h0;
            pcfg_ff <= 16'h0000;
            psel_ff <= 32'h0000_0000;
        end else if (clk_en && wr_en) begin
            if (sel_bank) begin
                bank_sel_ff <= wr_dat[0]; // R1
            end
            if (sel_m1) begin
                xmode_ff <= wr_dat[`GCFG_XMODE_LSB +: 2]; // R5
            end
            if (sel_m2) begin
                extsrc_ff <= wr_dat[`GCFG_EXTSRC_LSB +: 2]; // R6
            end
            if (sel_ien) begin
                in_en_ff <= wr_dat[2:0]; // R7
            end
            if (sel_oen) begin
                out_en_ff <= wr_dat[2:0]; // R8
            end
            if (sel_plo) begin
                pcfg_ff[7:0] <= wr_dat; // R12
            end
            if (sel_phi) begin
                pcfg_ff[15:8] <= wr_dat; // R12
            end
            if (sel_ps) begin
                psel_ff[ps_slot*8 +: 8] <= wr_dat; // R13
            end
        end
    end

    // Pin levels pass two flops before any logic reads them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
        end else if (clk_en) begin
            pin_meta_ff <= gpio_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Per-pin status selection and drive
    logic [3:0] nxt_gpio_out;
    logic [3:0] nxt_gpio_oe;
    generate
        for (genvar p = 0; p < 4; p++) begin : g_pin
            wire [3:0] code = pcfg_ff[p*4 +: 4];
            wire [4:0] reg_sel = psel_ff[p*8 + `GCFG_SEL_REG_LSB +: 5]; // R13
            wire [2:0] bit_sel = psel_ff[p*8 +: 3]; // R15
            wire [7:0] flat = {reg_sel, bit_sel};
            wire [7:0] sidx = `GCFG_IDX_STAT_BASE + 8'(reg_sel);
            // The pin level register is excluded to avoid a feedback loop
            wire is_lvl = sidx == `GCFG_IDX_PIN_LEVEL; // R16
            wire sval = status_impl[flat] && !is_lvl ?
                status_bits[flat] : 1'b0; // R14

            // Drive pair per code; open-drain codes only ever pull low
            always_comb begin
                nxt_gpio_out[p] = 1'b0;
                nxt_gpio_oe[p] = 1'b0;
                unique case (code)
                    gcfg_pkg::GCFG_PIN_OUT_LO: begin
                        nxt_gpio_oe[p] = 1'b1; // R9
                    end
                    gcfg_pkg::GCFG_PIN_OUT_HI: begin
                        nxt_gpio_out[p] = 1'b1;
                        nxt_gpio_oe[p] = 1'b1;
                    end
                    gcfg_pkg::GCFG_PIN_STAT: begin
                        nxt_gpio_out[p] = sval; // R10
                        nxt_gpio_oe[p] = 1'b1;
                    end
                    gcfg_pkg::GCFG_PIN_STAT_INV: begin
                        nxt_gpio_out[p] = !sval; // R10
                        nxt_gpio_oe[p] = 1'b1;
                    end
                    gcfg_pkg::GCFG_PIN_STAT_OD0: begin
                        nxt_gpio_oe[p] = !sval; // R10
                    end
                    gcfg_pkg::GCFG_PIN_STAT_OD1: begin
                        nxt_gpio_oe[p] = sval; // R10
                    end
                    // Inputs and unused codes leave the pin undriven
                    default: begin
                        nxt_gpio_oe[p] = 1'b0; // R9
                    end
                endcase
            end
        end
    endgenerate

    // Pin drive registered so data outputs come from flops
    always_ff @(posedge ref_clk) begin
        if (hold_rst) begin
            gpio_out_ff <= 4'h0;
            gpio_oe_ff <= 4'h0;
        end else if (clk_en) begin
            gpio_out_ff <= nxt_gpio_out;
            gpio_oe_ff <= nxt_gpio_oe;
        end
    end

    // Pin level status, as synchronised, regardless of mode
    wire [7:0] pin_level = {4'h0, pin_sync_ff}; // R11

    // Read decode; bank selector reads zero as it is write-only
    wire [7:0] rd_idx = s_axi_araddr[9:2];
    wire [4:0] rd_sreg = 5'(rd_idx - `GCFG_IDX_STAT_BASE);
    wire rd_stat = rd_idx > `GCFG_IDX_PIN_LEVEL &&
        rd_idx <= `GCFG_IDX_STAT_LAST;
    wire [1:0] rd_slot = 2'(rd_idx - `GCFG_IDX_PSEL0);
    wire rd_ps = rd_idx >= `GCFG_IDX_PSEL0 && rd_idx <= `GCFG_IDX_PSEL3;
    logic [7:0] rd_byte;
    logic rd_ok;
    always_comb begin
        rd_byte = `GCFG_ZERO8;
        rd_ok = 1'b1;
        if (rd_idx == `GCFG_IDX_BANK_SEL) begin
            rd_byte = `GCFG_ZERO8; // R2
        end else if (rd_idx == `GCFG_IDX_MCFG_ONE) begin
            rd_byte = {soft_rst_ff, 5'h00, xmode_ff};
        end else if (rd_idx == `GCFG_IDX_MCFG_TWO) begin
            rd_byte = {1'b0, extsrc_ff, 5'h00};
        end else if (rd_idx == `GCFG_IDX_IN_EN) begin
            rd_byte = {5'h00, in_en_ff};
        end else if (rd_idx == `GCFG_IDX_OUT_EN) begin
            rd_byte = {5'h00, out_en_ff};
        end else if (rd_idx == `GCFG_IDX_PCFG_LO) begin
            rd_byte = pcfg_ff[7:0];
        end else if (rd_idx == `GCFG_IDX_PCFG_HI) begin
            rd_byte = pcfg_ff[15:8];
        end else if (rd_ps) begin
            rd_byte = psel_ff[rd_slot*8 +: 8];
        end else if (rd_idx == `GCFG_IDX_PIN_LEVEL) begin
            rd_byte = pin_level;
        end else if (rd_idx == `GCFG_IDX_STAT_BASE) begin
            rd_byte = status_bits[7:0];
        end else if (rd_stat) begin
            rd_byte = status_bits[rd_sreg*8 +: 8];
        end else begin
            // Unmapped index answers SLVERR with zero data
            rd_ok = 1'b0;
        end
    end

    // Write channel state; response one cycle after both halves arrive
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_idx_ff <= `GCFG_ZERO8;
            wdat_ff <= `GCFG_ZERO8;
            wstb_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `GCFG_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_known ? `GCFG_RESP_OKAY : `GCFG_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_got_ff <= 1'b1;
                    aw_idx_ff <= s_axi_awaddr[9:2];
                end
                if (w_take) begin
                    w_got_ff <= 1'b1;
                    wdat_ff <= s_axi_wdata[7:0];
                    wstb_ff <= s_axi_wstrb[0];
                end
                if (bvalid_ff && s_axi_bready) begin
                    bvalid_ff <= 1'b0;
                end
            end
        end
    end

    // Read channel; data one cycle after the address is taken
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `GCFG_RESP_OKAY;
        end else if (clk_en) begin
            // arready is !rvalid_ff here, so this is the address handshake
            if (s_axi_arvalid && !rvalid_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= {24'h00_0000, rd_byte};
                rresp_ff <= rd_ok ? `GCFG_RESP_OKAY : `GCFG_RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Bus answers come straight from their registers
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Pin drive and controls toward the rest of the device
    assign gpio_out = gpio_out_ff;
    assign gpio_oe = gpio_oe_ff;
    assign eeprom_bank_select = bank_sel_ff; // R1
    assign core_reset = hold_rst; // R3
    assign crystal_pin_mode = xmode_ff; // R5
    // Switch source only meaningful while the enable is set; it lags the
    // pad by the two synchroniser clocks
    assign ext_switch_pin = ext_switch_enable &&
        pin_sync_ff[extsrc_ff]; // R6
    assign input_clock_enables = in_en_ff; // R7
    assign output_clock_enables = out_en_ff; // R8

endmodule

// file: tb/gcfg_regs_sva.sv
/* Checker of the bank's bus handshakes, soft reset and strap reload.
 * Assumes a bind to gcfg_regs, with clk_en low only while the bus idles. */
`timescale 1ns/1ns

module gcfg_regs_sva (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] crystal_mode_strap,
    input wire logic ext_switch_pin,
    input wire logic ext_switch_enable,
    input wire logic core_reset,
    input wire logic [1:0] crystal_pin_mode,
    input wire logic [2:0] input_clock_enables,
    input wire logic [2:0] output_clock_enables
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("no rvalid");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    a_soft_clears: assert property (
        core_reset && $past(core_reset) |-> input_clock_enables == 3'h0 &&
        output_clock_enables == 3'h0) else $error("enables kept in reset");
    a_strap_reload: assert property (
        $fell(reset) |-> crystal_pin_mode == $past(crystal_mode_strap))
        else $error("strap not caught");
    a_switch_gated: assert property (
        !ext_switch_enable |-> !ext_switch_pin) else $error("switch ungated");

    // Main scenarios: both bus directions and a soft reset
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_soft: cover property (core_reset && !$past(core_reset));
endmodule

bind gcfg_regs gcfg_regs_sva i_gcfg_regs_sva (.ref_clk(ref_clk),
    .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .crystal_mode_strap(crystal_mode_strap),
    .ext_switch_pin(ext_switch_pin), .ext_switch_enable(ext_switch_enable),
    .core_reset(core_reset), .crystal_pin_mode(crystal_pin_mode),
    .input_clock_enables(input_clock_enables),
    .output_clock_enables(output_clock_enables));

// file: tb/gcfg_regs_test.sv
/* Self-checking bench of gcfg_regs: an AXI4-Lite master with random stalls,
 * pin and status stimulus. Assumes the defines header on the include path. */
`timescale 1ns/1ns
`include "gcfg_defines.svh"

module gcfg_regs_test;
    logic ref_clk, reset, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, v;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, eeprom_bank_select;
    logic core_reset, ext_switch_pin, ext_switch_enable;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, w;
    logic [3:0] s_axi_wstrb, gpio_in, gpio_out, gpio_oe, mode;
    logic [1:0] s_axi_bresp, s_axi_rresp, crystal_mode_strap, crystal_pin_mode;
    logic [255:0] status_bits, status_impl;
    logic [2:0] input_clock_enables, output_clock_enables;
    logic [7:0] sel;
    logic [33:0] exp_q[$];
    int mismatches, comparisons, seed;
    localparam logic [7:0] IDX[9] = '{8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0E,
        8'h0F, 8'h12, 8'h13, 8'h14};
    localparam logic [7:0] MSK[9] = '{8'h03, 8'h60, 8'h07, 8'h07, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF};

    gcfg_regs i_gcfg_regs (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .crystal_mode_strap(crystal_mode_strap),
        .status_bits(status_bits), .status_impl(status_impl),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .eeprom_bank_select(eeprom_bank_select), .core_reset(core_reset),
        .crystal_pin_mode(crystal_pin_mode), .ext_switch_pin(ext_switch_pin),
        .ext_switch_enable(ext_switch_enable),
        .input_clock_enables(input_clock_enables),
        .output_clock_enables(output_clock_enables));

    // 125 MHz clock
    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [33:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One access; answer readies stall at random but never drop early
    task automatic acc(input logic rd, input logic [7:0] idx, d,
        input logic [33:0] e);
        logic done;
        logic go;
        exp_q.push_back(e);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_araddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_arvalid <= rd;
        s_axi_awvalid <= !rd;
        s_axi_wvalid <= !rd;
        done = 1'h0;
        // Waits for the answer however long; only the watchdog ends a hang
        while (!done) begin
            @(posedge ref_clk);
            done = rd ? s_axi_rvalid && s_axi_rready
                : s_axi_bvalid && s_axi_bready;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            go = ($random(seed) & 1) != 0;
            s_axi_bready <= !rd && !done && (s_axi_bready || go);
            s_axi_rready <= rd && !done && (s_axi_rready || go);
        end
    endtask

    task automatic wr(input logic [7:0] idx, d);
        acc(1'h0, idx, d, 34'h0_0000_0000);
    endtask

    task automatic rd(input logic [7:0] idx, d);
        acc(1'h1, idx, 8'h00, {26'h000_0000, d});
    endtask

    // Pin drive pair {enable, driven value}, after the register latency
    task automatic pin(input int p, input logic [1:0] e);
        repeat (3) @(posedge ref_clk);
        chk("pin", {32'h0, gpio_oe[p], gpio_oe[p] & gpio_out[p]}, {32'h0, e});
    endtask

    // Answers are matched in order against the notes left by acc
    always @(posedge ref_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end else if (s_axi_bvalid && s_axi_bready) begin
            chk("write", {s_axi_bresp, 32'h0}, exp_q.pop_front());
        end
    end

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        seed = 32'h80a7_c49a;
        mismatches = 0;
        comparisons = 0;
        {reset, clk_en, s_axi_wstrb} = 6'h3F;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready, ext_switch_enable} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
        {crystal_mode_strap, gpio_in} = 6'h20;
        {status_bits, status_impl} = 512'h0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'h0;
        @(posedge ref_clk);
        // Defaults, strap-loaded crystal mode, then masked read-back
        rd(8'h09, 8'h02);
        foreach (IDX[i]) begin
            if (i > 0) rd(IDX[i], 8'h00);
            w = $random(seed);
            wr(IDX[i], w[7:0] & MSK[i]);
            rd(IDX[i], w[7:0] & MSK[i]);
            if (i == 0) chk("xmode", 34'(crystal_pin_mode), 34'(w[1:0]));
            if (i == 2) chk("inen", 34'(input_clock_enables), 34'(w[2:0]));
            if (i == 3) chk("outen", 34'(output_clock_enables), 34'(w[2:0]));
        end
        wr(8'h00, 8'h01);
        chk("bank", 34'(eeprom_bank_select), 34'h1);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h00);
        chk("bank", 34'(eeprom_bank_select), 34'h0);
        acc(1'h0, 8'h01, 8'h5A, {`GCFG_RESP_SLVERR, 32'h0});
        acc(1'h1, 8'h30, 8'h00, {`GCFG_RESP_SLVERR, 32'h0});
        $display("test registers done");
        // Plain codes on every pin, then the live pin levels
        for (int p = 0; p < 4; p++) for (int c = 0; c < 4; c++) begin
            wr(p < 2 ? 8'h0E : 8'h0F, 8'(c << (4 * (p % 2))));
            pin(p, c < 2 ? 2'h0 : {1'h1, c[0]});
        end
        w = $random(seed);
        gpio_in <= w[3:0];
        repeat (4) @(posedge ref_clk);
        rd(8'h41, {4'h0, w[3:0]});
        $display("test pin codes done");
        // Status following; the first pick is the pin level register
        // Bit 0 of the pin level register is live, so the exclusion shows
        status_bits <= {8{$random(seed)}} | 256'h100;
        status_impl <= {8{$random(seed)}} | 256'h100;
        gpio_in <= 4'hF;
        for (int i = 0; i < 12; i++) begin
            sel = i == 0 ? 8'h08 : 8'($random(seed));
            v = sel[7:3] != 5'h01 && status_impl[sel];
            mode = v ? 4'(4 + ($random(seed) & 3)) : 4'h4;
            v = v && status_bits[sel];
            wr(8'h12, sel);
            wr(8'h0E, {4'h0, mode});
            pin(0, mode[1] ? {mode[0] == v, 1'h0} : {1'h1, v ^ mode[0]});
        end
        $display("test status follow done");
        // Switch source picks each pin; enable toggles between passes
        for (int s = 0; s < 4; s++) begin
            w = $random(seed);
            gpio_in <= w[3:0];
            ext_switch_enable <= s[0];
            wr(8'h0A, 8'(s << 5));
            repeat (3) @(posedge ref_clk);
            chk("switch", 34'(ext_switch_pin), 34'(s[0] & w[s]));
        end
        // Clock enable low freezes the synchroniser, so the switch holds
        clk_en <= 1'h0;
        gpio_in <= ~w[3:0];
        repeat (4) @(posedge ref_clk);
        chk("frozen", 34'(ext_switch_pin), 34'(w[3]));
        clk_en <= 1'h1;
        $display("test switch done");
        // Soft reset; a changed strap must not be resampled
        wr(8'h0C, 8'h07);
        wr(8'h0D, 8'h07);
        wr(8'h0E, 8'h33);
        crystal_mode_strap <= 2'h1;
        wr(8'h09, 8'h81);
        @(posedge ref_clk);
        chk("soft", 34'({core_reset, input_clock_enables, output_clock_enables,
            crystal_pin_mode, gpio_oe}), 34'h1020);
        rd(8'h0C, 8'h00);
        wr(8'h09, 8'h00);
        chk("run", 34'({core_reset, crystal_pin_mode}), 34'h2);
        reset <= 1'h1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'h0;
        @(posedge ref_clk);
        chk("strap", 34'(crystal_pin_mode), 34'h1);
        $display("test soft reset done");
        end_of_test();
    end
endmodule
